// ===== bcdc_defines.svh
`ifndef BCDC_DEFINES_SVH
`define BCDC_DEFINES_SVH

// Register offsets (word index on the plain register port)
`define BCDC_OFS_MIN_SEC 2'h0
`define BCDC_OFS_DAY_HOUR 2'h1
`define BCDC_OFS_YEAR_MONTH 2'h2
`define BCDC_OFS_WDAY_CTRL 2'h3

// Control bit positions in the weekday and control word
`define BCDC_BIT_ROUND 13
`define BCDC_BIT_HALT 14
`define BCDC_BIT_LOAD 15

// Reset values
`define BCDC_RST_SEC 8'h00
`define BCDC_RST_MIN 8'h00
`define BCDC_RST_HOUR 8'h00
`define BCDC_RST_DAY 8'h01
`define BCDC_RST_MONTH 8'h01
`define BCDC_RST_YEAR 8'h00
`define BCDC_RST_WDAY 8'h00

// Default scan-cycle length in core clocks (1 ms at 20 MHz)
`define BCDC_SCAN_NS 1000000
`define BCDC_CLK_NS 50
`define BCDC_SCAN_CYC (`BCDC_SCAN_NS / `BCDC_CLK_NS)
// Default second length in core clocks (1 s at 20 MHz)
`define BCDC_SEC_NS 1000000000
`define BCDC_SEC_CYC (`BCDC_SEC_NS / `BCDC_CLK_NS)

`endif

// ===== bcdc_pkg.sv
`default_nettype none
package bcdc_pkg;

	// Calendar and time fields, each one BCD byte
	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] day;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
		logic [7:0] wday;
	} bcdc_time_s;

	// Register port request
	typedef struct packed {
		logic [1:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} bcdc_req_s;

endpackage
`default_nettype wire

// ===== bcdc_clock.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcdc_defines.svh"

// Function
// - Counting advances while halt is clear; while halt is set only a load changes the fields.
// - Seconds and minutes run 00 to 59 BCD and hours 00 to 23 BCD in 24-hour form.
// - Day runs 01 up to the month length with leap years, and month runs 1 to 12 BCD.
// - Year holds the two low decimal digits, 00 to 99 BCD.
// - Weekday runs 00 for Sunday up to 06 for Saturday.
// - Rounding with seconds at 29 or below clears seconds and leaves minutes alone.
// - Rounding with seconds at 30 or above adds one minute and clears seconds.
// - Setting load adopts the written values, resumes counting, and clears load and halt.
// - The visible words are refreshed once every scan cycle while running.
module bcdc_clock #(
	parameter int unsigned SEC_CYC = `BCDC_SEC_CYC,
	parameter int unsigned SCAN_CYC = `BCDC_SCAN_CYC
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic running
);

	// ****************************************
	// Bus request bundle
	// ****************************************
	bcdc_pkg::bcdc_req_s req;
	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	// ****************************************
	// State
	// ****************************************
	bcdc_pkg::bcdc_time_s cnt_q, cnt_d;   // Live counter
	bcdc_pkg::bcdc_time_s shad_q, shad_d; // Software-written values
	bcdc_pkg::bcdc_time_s vis_q, vis_d;   // Visible words
	logic halt_q, halt_d;
	logic load_q, load_d;
	logic round_q, round_d;
	logic [31:0] sec_cnt_q, sec_cnt_d;
	logic [31:0] scan_cnt_q, scan_cnt_d;
	logic [15:0] rdata_q, rdata_d;

	// ****************************************
	// BCD helpers
	// ****************************************
	// Steps one BCD byte; the caller decides where it wraps
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		logic [7:0] r;
		r = v;
		if (v[3:0] == 4'h9) begin
			r = {v[7:4] + 4'h1, 4'h0};
		end else begin
			r = {v[7:4], v[3:0] + 4'h1};
		end
		return r;
	endfunction

	// Last day of the month, February following the leap years
	function automatic logic [7:0] month_len(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		logic [7:0] r;
		// BCD year divisible by 4: tens even with units 0/4/8, tens odd with 2/6
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		case (mon)
			8'h02: r = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
			default: r = 8'h31;
		endcase
		return r;
	endfunction

	// ****************************************
	// Timing and control decode
	// ****************************************
	wire sec_tick = (sec_cnt_q == SEC_CYC - 1);
	wire scan_tick = (scan_cnt_q == SCAN_CYC - 1);
	wire wr_ctrl = req.wr && (req.addr == `BCDC_OFS_WDAY_CTRL);
	wire do_round = round_q && !halt_q && !load_q;
	wire round_up = (cnt_q.sec >= 8'h30);
	wire advance = sec_tick && !halt_q && !load_q;

	// ****************************************
	// Field wrap decode
	// ****************************************
	// Top value of each field, where it wraps to its bottom; all but year and weekday also carry
	wire [7:0] day_last = month_len(cnt_q.month, cnt_q.year);
	wire sec_last = (cnt_q.sec == 8'h59);
	wire min_last = (cnt_q.min == 8'h59);
	wire hour_last = (cnt_q.hour == 8'h23);
	wire day_last_hit = (cnt_q.day == day_last);
	wire month_last = (cnt_q.month == 8'h12);
	wire year_last = (cnt_q.year == 8'h99);
	wire wday_last = (cnt_q.wday == 8'h06);

	// Next BCD value of each field when it steps without wrapping
	wire [7:0] sec_step = bcd_inc(cnt_q.sec);
	wire [7:0] min_step = bcd_inc(cnt_q.min);
	wire [7:0] hour_step = bcd_inc(cnt_q.hour);
	wire [7:0] day_step = bcd_inc(cnt_q.day);
	wire [7:0] month_step = bcd_inc(cnt_q.month);
	wire [7:0] year_step = bcd_inc(cnt_q.year);
	wire [7:0] wday_step = bcd_inc(cnt_q.wday);

	// ****************************************
	// Write decode
	// ****************************************
	// One strobe per word; only the shadow copy takes the data
	wire wr_min_sec = req.wr && (req.addr == `BCDC_OFS_MIN_SEC);
	wire wr_day_hour = req.wr && (req.addr == `BCDC_OFS_DAY_HOUR);
	wire wr_year_month = req.wr && (req.addr == `BCDC_OFS_YEAR_MONTH);

	// ****************************************
	// Counter next state with carry chain
	// ****************************************
	// Load first, then rounding, then the second tick; carries ripple upward
	always_comb begin
		logic c_min;
		logic c_hour;
		logic c_day;
		logic c_mon;
		logic c_year;
		cnt_d = cnt_q;
		c_min = 1'b0;
		c_hour = 1'b0;
		c_day = 1'b0;
		c_mon = 1'b0;
		c_year = 1'b0;
		if (load_q) begin
			cnt_d = shad_q;
		end else if (do_round) begin
			cnt_d.sec = 8'h00;
			c_min = round_up;
		end else if (advance) begin
			if (sec_last) begin
				cnt_d.sec = 8'h00;
				c_min = 1'b1;
			end else begin
				cnt_d.sec = sec_step;
			end
		end
		if (c_min) begin
			if (min_last) begin
				cnt_d.min = 8'h00;
				c_hour = 1'b1;
			end else begin
				cnt_d.min = min_step;
			end
		end
		if (c_hour) begin
			if (hour_last) begin
				cnt_d.hour = 8'h00;
				c_day = 1'b1;
			end else begin
				cnt_d.hour = hour_step;
			end
		end
		if (c_day) begin
			cnt_d.wday = wday_last ? 8'h00 : wday_step;
			if (day_last_hit) begin
				cnt_d.day = 8'h01;
				c_mon = 1'b1;
			end else begin
				cnt_d.day = day_step;
			end
		end
		if (c_mon) begin
			if (month_last) begin
				cnt_d.month = 8'h01;
				c_year = 1'b1;
			end else begin
				cnt_d.month = month_step;
			end
		end
		if (c_year) begin
			cnt_d.year = year_last ? 8'h00 : year_step;
		end
	end

	// ****************************************
	// Shadow fields, control bits and timers
	// ****************************************
	// Shadow copy takes each written word; the live counter never does
	always_comb begin
		shad_d = shad_q;
		if (wr_min_sec) begin
			{shad_d.min, shad_d.sec} = req.wdata;
		end
		if (wr_day_hour) begin
			{shad_d.day, shad_d.hour} = req.wdata;
		end
		if (wr_year_month) begin
			{shad_d.year, shad_d.month} = req.wdata;
		end
		if (wr_ctrl) begin
			shad_d.wday = req.wdata[7:0];
		end
	end

	// Load and halt clear themselves after a load; a write in the same cycle wins
	always_comb begin
		halt_d = halt_q;
		load_d = load_q;
		if (load_q) begin
			load_d = 1'b0;
			halt_d = 1'b0;
		end
		if (wr_ctrl) begin
			halt_d = req.wdata[`BCDC_BIT_HALT];
			load_d = req.wdata[`BCDC_BIT_LOAD];
		end
	end

	// Rounding request: cleared once applied, a new set in that cycle wins
	always_comb begin
		round_d = round_q;
		if (do_round) begin
			round_d = 1'b0;
		end
		if (wr_ctrl && req.wdata[`BCDC_BIT_ROUND]) begin
			round_d = 1'b1;
		end
	end

	// Second prescaler restarts while halted or loading, so a load starts a full second
	assign sec_cnt_d = (sec_tick || halt_q || load_q) ? 32'h0 : sec_cnt_q + 32'h1;
	// Scan counter runs free; each wrap is one scan cycle
	assign scan_cnt_d = scan_tick ? 32'h0 : scan_cnt_q + 32'h1;

	// ****************************************
	// Visible words, refreshed each scan while not halted
	// ****************************************
	assign vis_d = (scan_tick && !halt_q) ? cnt_q : vis_q;

	// ****************************************
	// Read mux
	// ****************************************
	// Fields from the visible copy, control bits live, zero when no read
	always_comb begin
		rdata_d = 16'h0000;
		if (req.rd) begin
			case (req.addr)
				`BCDC_OFS_MIN_SEC: rdata_d = {vis_q.min, vis_q.sec};
				`BCDC_OFS_DAY_HOUR: rdata_d = {vis_q.day, vis_q.hour};
				`BCDC_OFS_YEAR_MONTH: rdata_d = {vis_q.year, vis_q.month};
				default: begin
					rdata_d = {8'h00, vis_q.wday};
					rdata_d[`BCDC_BIT_ROUND] = round_q;
					rdata_d[`BCDC_BIT_HALT] = halt_q;
					rdata_d[`BCDC_BIT_LOAD] = load_q;
				end
			endcase
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	// Reset image of the calendar and time fields
	localparam bcdc_pkg::bcdc_time_s RST_TIME = '{year: `BCDC_RST_YEAR,
		month: `BCDC_RST_MONTH, day: `BCDC_RST_DAY, hour: `BCDC_RST_HOUR,
		min: `BCDC_RST_MIN, sec: `BCDC_RST_SEC, wday: `BCDC_RST_WDAY};

	// Live counter
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= RST_TIME;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Software-written shadow copy
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			shad_q <= RST_TIME;
		end else begin
			shad_q <= shad_d;
		end
	end

	// Visible words
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			vis_q <= RST_TIME;
		end else begin
			vis_q <= vis_d;
		end
	end

	// Control bits
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			halt_q <= 1'b0;
			load_q <= 1'b0;
			round_q <= 1'b0;
		end else begin
			halt_q <= halt_d;
			load_q <= load_d;
			round_q <= round_d;
		end
	end

	// Second prescaler and scan counter
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sec_cnt_q <= 32'h0;
			scan_cnt_q <= 32'h0;
		end else begin
			sec_cnt_q <= sec_cnt_d;
			scan_cnt_q <= scan_cnt_d;
		end
	end

	// Read data, standing for one cycle after the strobe
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Registered read data and the run indicator
	assign reg_rdata = rdata_q;
	assign running = !halt_q; // Counting enabled

endmodule
`default_nettype wire

// ===== bcdc_clock_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Checker
// ****
module bcdc_chk (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic running
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	logic [2:0] rq_q;
	// Last read strobe and word
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) rq_q <= 3'h0;
		else rq_q <= {reg_rd, reg_addr};
	end
	// Field ranges in each read answer
	a_sec_range: assert property (rq_q == 3'h4 |->
		reg_rdata[7:0] <= 8'h59 && reg_rdata[15:8] <= 8'h59
		&& reg_rdata[3:0] <= 4'h9 && reg_rdata[11:8] <= 4'h9) else $error("bad sec");
	a_hour_range: assert property (rq_q == 3'h5 |->
		reg_rdata[7:0] <= 8'h23) else $error("bad hour");
	a_day_range: assert property (rq_q == 3'h5 |->
		reg_rdata[15:8] inside {[8'h01:8'h31]}) else $error("bad day");
	a_month_range: assert property (rq_q == 3'h6 |->
		reg_rdata[7:0] inside {[8'h01:8'h12]}) else $error("bad month");
	a_year_bcd: assert property (rq_q == 3'h6 |->
		reg_rdata[15:12] <= 4'h9 && reg_rdata[11:8] <= 4'h9) else $error("bad year");
	a_wday_range: assert property (rq_q == 3'h7 |->
		reg_rdata[7:0] <= 8'h06) else $error("bad weekday");
	// Control bit effects
	a_halt_stops: assert property (reg_wr && reg_addr == 2'h3 &&
		reg_wdata[15:14] == 2'h1 |=> !running) else $error("halt ignored");
	a_load_runs: assert property (reg_wr && reg_addr == 2'h3 &&
		reg_wdata[15] |-> ##[1:3] running) else $error("load kept halt");
endmodule
`default_nettype wire

// ===== bcdc_clock_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bcdc_clock_tb;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	bcdc_pkg::bcdc_req_s req = '0;
	logic [15:0] reg_rdata;
	logic running;
	int fails = 0;
	int checked = 0;
	// Clock, short second and scan
	always #25 core_clk = ~core_clk;
	bcdc_clock #(.SEC_CYC(20), .SCAN_CYC(4)) dut_u (.core_clk(core_clk), .reset_n(reset_n),
		.reg_addr(req.addr), .reg_wdata(req.wdata), .reg_wr(req.wr), .reg_rd(req.rd),
		.reg_rdata(reg_rdata), .running(running));
	// ****
	// Bus and compare tasks
	// ****
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge core_clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, input logic [15:0] exp);
		@(posedge core_clk);
		req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		req.rd <= 1'b0;
		#1 cmp(reg_rdata, exp);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// Halt, write fields, then load
	task automatic set(input logic [15:0] w0, w1, w2, input logic [7:0] wd);
		wr(2'h3, {8'h40, wd});
		wr(2'h0, w0);
		wr(2'h1, w1);
		wr(2'h2, w2);
		wr(2'h3, {8'hC0, wd});
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_reset();
		rd(2'h0, 16'h0000);
		rd(2'h1, 16'h0100);
		rd(2'h2, 16'h0001);
		rd(2'h3, 16'h0000);
		$display("reset test done");
	endtask
	// Midnight carries through month, year, leap day, weekday
	task automatic t_roll();
		logic [15:0] t [4][5] = '{'{16'h3123, 16'h9912, 6, 16'h0100, 16'h0001},
			'{16'h2823, 16'h2402, 3, 16'h2900, 16'h2402},
			'{16'h2823, 16'h2302, 3, 16'h0100, 16'h2303},
			'{16'h3023, 16'h2504, 5, 16'h0100, 16'h2505}};
		for (int i = 0; i < 4; i++) begin
			set(16'h5959, t[i][0], t[i][1], t[i][2][7:0]);
			idle(27);
			rd(2'h0, 16'h0000);
			rd(2'h1, t[i][3]);
			rd(2'h2, t[i][4]);
			rd(2'h3, (t[i][2] + 16'h1) % 16'h7);
			cmp({15'h0, running}, 16'h0001);
		end
		$display("rollover test done");
	endtask
	task automatic t_halt();
		set(16'h2005, 16'h0110, 16'h2501, 8'h02);
		idle(27);
		rd(2'h0, 16'h2006);
		wr(2'h3, 16'h4002);
		idle(60);
		rd(2'h0, 16'h2006);
		rd(2'h3, 16'h4002);
		cmp({15'h0, running}, 16'h0000);
		$display("halt test done");
	endtask
	task automatic t_round();
		logic [15:0] r [2][3] = '{'{16'h2029, 16'h2000, 16'h2001},
			'{16'h2030, 16'h2100, 16'h2101}};
		for (int i = 0; i < 2; i++) begin
			set(r[i][0], 16'h0110, 16'h2501, 8'h02);
			wr(2'h3, 16'h2002);
			idle(6);
			rd(2'h0, r[i][1]);
			idle(18);
			rd(2'h0, r[i][2]);
			rd(2'h3, 16'h0002);
		end
		$display("round test done");
	endtask
	task automatic complete_run();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		idle(8);
		reset_n <= 1'b1;
		t_reset();
		t_roll();
		t_halt();
		t_round();
		complete_run();
	end
	// Watchdog
	initial begin
		idle(5000);
		fails++;
		complete_run();
	end
endmodule
bind bcdc_clock bcdc_chk chk_u (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.running(running));
`default_nettype wire
